// *** common/autoneg_adv_pkg.sv ***
// constants for the auto-negotiation advertisement register bank
// assumes a 32-bit Avalon-MM slave with byte addresses and one word per register
package autoneg_adv_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int REG_W = 16;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PHY_CONTROL_OFS = 8'h00;
	localparam logic [7:0] AUTONEG_ADVERT_OFS = 8'h04;
	localparam logic [7:0] ACTIVE_ADVERT_OFS = 8'h08;

	// ----------------------------------------------------------------
	// advertisement layout
	// ----------------------------------------------------------------
	localparam logic [15:0] ADVERT_RESET = 16'h01e1;
	// only remote fault and the four ability bits take writes
	localparam logic [15:0] ADVERT_WMASK = 16'h21e0;
	localparam logic [15:0] ADVERT_RSVD_MASK = 16'h5e00;
	localparam int NEXT_PAGE_BIT = 15;
	localparam int REMOTE_FAULT_BIT = 13;
	localparam int TECH_HI = 8;
	localparam int TECH_LO = 5;
	localparam int TECH_100FD_BIT = 8;
	localparam int TECH_10FD_BIT = 6;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 0;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;

	// ----------------------------------------------------------------
	// control layout
	// ----------------------------------------------------------------
	localparam int RESTART_BIT = 9;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

endpackage

// *** rtl/masked_reg.sv ***
// one register with per-bit write mask and byte-lane enables
// assumes writes arrive as a single-cycle strobe in the clk domain
`timescale 1ns/10ps
module masked_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] WMASK = '1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [(WIDTH+7)/8-1:0] byteEn,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] laneMask;

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			laneMask[i] = byteEn[i/8] & WMASK[i];
		end
	end

	// non-writable bits never leave their reset value
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_VAL;
		end else if (wrEn) begin
			q <= (q & ~laneMask) | (wrData & laneMask);
		end
	end

endmodule

// *** rtl/autoneg_advertisement_reg.sv ***
// auto-negotiation advertisement register with its restart control
// assumes an Avalon-MM master on clk; the negotiation engine reads advertBasePage
// Contract
// - written advertisement is applied only when negotiation is restarted
// - bits 8:5 hold the technology ability field, software writable
// - advertisement resets to 0x01e1
// - bit 15 next page flag is read-only zero
// - bit 13 remote fault is writable, resets zero, advertised to partner
// - bits 14 and 12:9 reserved, read zero, ignore writes
// - restart bit re-initiates negotiation using current advertisement
// - bit 8 advertises 100 full duplex, bit 6 10 full duplex
`timescale 1ns/10ps
module autoneg_advertisement_reg
	import autoneg_adv_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [autoneg_adv_pkg::DATA_W-1:0] writedata,
	input wire logic [autoneg_adv_pkg::BE_W-1:0] byteenable,
	output logic [autoneg_adv_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	output logic [autoneg_adv_pkg::REG_W-1:0] advertBasePage,
	output logic restartAutoneg
);
	import autoneg_adv_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 4 || ADDR_W > 8) begin : gBadAddr
		$error("ADDR_W must lie between 4 and 8");
	end

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// one wait cycle then a single accept cycle; keeps readdata a flop
	logic waitrequest_q;
	logic accept;
	logic [7:0] byteAddr;
	logic hitAdvert;
	logic hitControl;
	logic hitActive;
	logic advertWr;
	logic restartWr;

	assign waitrequest = waitrequest_q;
	assign accept = (read | write) & ~waitrequest_q;
	assign byteAddr = 8'(address);
	assign hitAdvert = (byteAddr == AUTONEG_ADVERT_OFS);
	assign hitControl = (byteAddr == PHY_CONTROL_OFS);
	assign hitActive = (byteAddr == ACTIVE_ADVERT_OFS);
	assign advertWr = accept & write & hitAdvert;
	assign restartWr = accept & write & hitControl & byteenable[1] & writedata[RESTART_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			waitrequest_q <= 1'b1;
		end else if ((read | write) & waitrequest_q) begin
			waitrequest_q <= 1'b0;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// advertisement storage
	// ----------------------------------------------------------------
	logic [REG_W-1:0] advert_q;

	// masked bits keep next page, reserved and selector constant
	masked_reg #(
		.WIDTH(REG_W),
		.RESET_VAL(ADVERT_RESET),
		.WMASK(ADVERT_WMASK)
	) uAdvert (
		.clk(clk),
		.rst(rst),
		.wrEn(advertWr),
		.wrData(writedata[REG_W-1:0]),
		.byteEn(byteenable[1:0]),
		.q(advert_q)
	);

	// ----------------------------------------------------------------
	// restart and applied advertisement
	// ----------------------------------------------------------------
	logic [REG_W-1:0] activeAdvert_q;
	logic restart_q;

	// restart bit self-clears; a pulse tells the engine to start over
	always_ff @(posedge clk) begin
		if (rst) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= restartWr;
		end
	end

	// writes land in advert_q only; the engine sees them after restart
	always_ff @(posedge clk) begin
		if (rst) begin
			activeAdvert_q <= ADVERT_RESET;
		end else if (restartWr) begin
			activeAdvert_q <= advert_q;
		end
	end

	assign advertBasePage = activeAdvert_q;
	assign restartAutoneg = restart_q;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] readdata_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata_q <= '0;
		end else if (read & waitrequest_q) begin
			if (hitAdvert) begin
				readdata_q <= {{(DATA_W-REG_W){1'b0}}, advert_q};
			end else if (hitActive) begin
				readdata_q <= {{(DATA_W-REG_W){1'b0}}, activeAdvert_q};
			end else if (hitControl) begin
				readdata_q <= {{(DATA_W-REG_W){1'b0}}, CONTROL_RESET};
			end else begin
				readdata_q <= '0;
			end
		end
	end

	assign readdata = readdata_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_APPLY_ONLY_ON_RESTART: assert property (@(posedge clk) disable iff (rst)
		advertWr && !restartWr |=> activeAdvert_q == $past(activeAdvert_q))
		else $error("advertisement applied without restart");

	AST_TECH_FIELD_WRITE: assert property (@(posedge clk) disable iff (rst)
		advertWr && byteenable[0] && byteenable[1]
		|=> advert_q[TECH_HI:TECH_LO] == $past(writedata[TECH_HI:TECH_LO]))
		else $error("technology field did not take write");

	AST_RESET_VALUE: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> advert_q == ADVERT_RESET && activeAdvert_q == ADVERT_RESET)
		else $error("advertisement reset value wrong");

	AST_NEXT_PAGE_ZERO: assert property (@(posedge clk) disable iff (rst)
		!waitrequest_q && read && hitAdvert |-> !readdata_q[NEXT_PAGE_BIT])
		else $error("next page flag read as one");

	AST_REMOTE_FAULT_WRITE: assert property (@(posedge clk) disable iff (rst)
		advertWr && byteenable[1]
		|=> advert_q[REMOTE_FAULT_BIT] == $past(writedata[REMOTE_FAULT_BIT]))
		else $error("remote fault bit did not take write");

	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (rst)
		advertWr |=> (advert_q & ADVERT_RSVD_MASK) == '0 ##1 (advert_q & ADVERT_RSVD_MASK) == '0)
		else $error("reserved bits became nonzero");

	AST_RESTART_APPLIES: assert property (@(posedge clk) disable iff (rst)
		restartWr |=> restartAutoneg && advertBasePage == $past(advert_q) ##1 !restartAutoneg)
		else $error("restart did not apply current advertisement");

	AST_FULL_DUPLEX_RESET: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> advertBasePage[TECH_100FD_BIT] && advertBasePage[TECH_10FD_BIT])
		else $error("full duplex abilities not set after reset");

	AST_SELECTOR: assert property (@(posedge clk) disable iff (rst)
		advert_q[SEL_HI:SEL_LO] == SELECTOR_8023 && advertBasePage[SEL_HI:SEL_LO] == SELECTOR_8023)
		else $error("selector field not 802.3");

	AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (rst)
		(read || write) && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
		else $error("bus answer timing wrong");

endmodule

// *** sim/link_partner_model.sv ***
// link partner stand-in: keeps the last base page offered on restart
// assumes restartAutoneg is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
module link_partner_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic restartAutoneg,
	input wire logic [15:0] advertBasePage,
	output logic [15:0] rxPage_q,
	output logic [7:0] rxCount_q
);
	// counts every cycle that restart stands, so a stretched pulse shows
	always_ff @(posedge clk) begin
		if (rst) begin
			rxPage_q <= 16'h0000;
			rxCount_q <= 8'h00;
		end else if (restartAutoneg) begin
			rxPage_q <= advertBasePage;
			rxCount_q <= rxCount_q + 8'h01;
		end
	end
endmodule

// *** sim/tb.sv ***
// bench for the advertisement register over Avalon-MM
// assumes the link partner model and the design package are compiled first
`timescale 1ns/10ps
module tb;
	import autoneg_adv_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata, rd, e;
	logic waitrequest, restartAutoneg;
	logic [15:0] advertBasePage, rxPage_q;
	logic [7:0] rxCount_q;
	int n_fail = 0;
	int tests_run = 0;
	always #20 clk = ~clk;
	autoneg_advertisement_reg i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .advertBasePage(advertBasePage),
		.restartAutoneg(restartAutoneg));
	link_partner_model i_partner (.clk(clk), .rst(rst), .restartAutoneg(restartAutoneg),
		.advertBasePage(advertBasePage), .rxPage_q(rxPage_q), .rxCount_q(rxCount_q));
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// request held until waitrequest is sampled low, then released
	task access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		byteenable <= be;
		// only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		access(1'b0, a, 32'h0, 4'hf);
		check(what, rd, exp);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		stop_test;
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		check("applied", {16'h0, advertBasePage}, {16'h0, ADVERT_RESET});
		rdchk(AUTONEG_ADVERT_OFS, 32'h01e1, "advert");
		access(1'b1, AUTONEG_ADVERT_OFS, 32'hffffffff, 4'hf);
		rdchk(AUTONEG_ADVERT_OFS, 32'h21e1, "advert ones");
		// let the accept edge settle, else a wrong apply would go unseen
		@(posedge clk);
		check("no apply", {16'h0, advertBasePage}, 32'h01e1);
		access(1'b1, AUTONEG_ADVERT_OFS, 32'h0, 4'h3);
		rdchk(AUTONEG_ADVERT_OFS, 32'h0001, "advert zero");
		access(1'b1, AUTONEG_ADVERT_OFS, 32'hffff, 4'h1);
		rdchk(AUTONEG_ADVERT_OFS, 32'h00e1, "low lane");
		access(1'b1, PHY_CONTROL_OFS, 32'h200, 4'h1);
		// a wrong restart would reach the partner two edges later
		repeat (2) @(posedge clk);
		check("lane0 restart", {24'h0, rxCount_q}, 32'h0);
		// each ability bit alone, with remote fault, then applied
		for (int i = 5; i <= 8; i++) begin
			e = 32'h2001 | (32'h1 << i);
			access(1'b1, AUTONEG_ADVERT_OFS, e, 4'h3);
			access(1'b1, PHY_CONTROL_OFS, 32'h200, 4'h2);
			rdchk(ACTIVE_ADVERT_OFS, e, "applied");
			check("partner page", {16'h0, rxPage_q}, e);
			check("restarts", {24'h0, rxCount_q}, 32'(i - 4));
		end
		rdchk(PHY_CONTROL_OFS, 32'h0, "control");
		access(1'b1, 8'h0c, 32'hffff, 4'hf);
		rdchk(8'h0c, 32'h0, "unmapped");
		access(1'b1, ACTIVE_ADVERT_OFS, 32'h0, 4'hf);
		rdchk(ACTIVE_ADVERT_OFS, e, "applied ro");
		// read-modify-write keeps reserved bits as read
		rdchk(AUTONEG_ADVERT_OFS, e, "advert");
		access(1'b1, AUTONEG_ADVERT_OFS, rd & ~32'h2000, 4'h3);
		rdchk(ACTIVE_ADVERT_OFS, e, "held");
		access(1'b1, PHY_CONTROL_OFS, 32'h200, 4'h2);
		rdchk(ACTIVE_ADVERT_OFS, 32'h0101, "applied rmw");
		check("partner rmw", {16'h0, rxPage_q}, 32'h0101);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(AUTONEG_ADVERT_OFS, 32'h01e1, "re-reset");
		check("re-reset applied", {16'h0, advertBasePage}, 32'h01e1);
		stop_test;
	end
endmodule
